// ==== rtl/strpi_pkg.sv ====
// Overview of operation
// - Instruction 3, bypass 1, ID 32, boundary 109 bits
// - ID bits 31:29 hold version number
// - ID bits 28:12 hold memory type code
// - ID bits 11:1 hold vendor code
// - ID bit 0 always reads one
// - Code 000 captures ring into boundary chain
// - Code 001 loads and shifts identification word
// - Code 010 samples ring and floats outputs
// - Code 100 samples ring, memory undisturbed
// - Code 111 selects single bypass cell
// - PLL follows main clock; host keeps jitter low
// - Cell 108 enables or floats read bus under code 000
// - Cell 108 preset one at reset
`default_nettype none
package strpi_pkg;

  // Scan path widths
  localparam int unsigned IR_W = 3;
  localparam int unsigned ID_W = 32;
  localparam int unsigned BSR_W = 109;
  localparam int unsigned RING_W = 108;
  localparam int unsigned OE_CELL = 108;

  // Identification word field positions
  localparam int unsigned ID_VER_LSB = 29;
  localparam int unsigned ID_TYPE_LSB = 12;
  localparam int unsigned ID_VEND_LSB = 1;
  localparam int unsigned ID_PRES_BIT = 0;

  // Instruction codes
  typedef enum logic [2:0] {
    INS_EXTEST = 3'h0,
    INS_IDCODE = 3'h1,
    INS_SAMPLE_Z = 3'h2,
    INS_RSVD_3 = 3'h3,
    INS_SAMPLE = 3'h4,
    INS_RSVD_5 = 3'h5,
    INS_RSVD_6 = 3'h6,
    INS_BYPASS = 3'h7
  } strpi_instr_e;

  // Capture pattern and reset values
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam strpi_instr_e IR_RESET = INS_IDCODE;
  localparam logic OE_CELL_RESET = 1'h1;

  // Control pin vector layout
  localparam int unsigned CTL_W = 10;
  localparam int unsigned C_TCK = 0;
  localparam int unsigned C_TDI = 1;
  localparam int unsigned C_TLR = 2;
  localparam int unsigned C_CDR = 3;
  localparam int unsigned C_SDR = 4;
  localparam int unsigned C_UDR = 5;
  localparam int unsigned C_CIR = 6;
  localparam int unsigned C_SIR = 7;
  localparam int unsigned C_UIR = 8;
  localparam int unsigned C_PLLN = 9;

  // PLL lock time
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned PLL_LOCK_US = 100;
  localparam int unsigned LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned LOCK_W = 12;

endpackage
`default_nettype wire

// ==== rtl/strpi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module strpi_sync #(
  parameter int unsigned W = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Raw and filtered levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  // Three stages plus accepted level
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } strpi_sync_s;

  strpi_sync_s q;
  strpi_sync_s d;

  // Accept a bit once stages two and three agree
  always_comb
  begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule
`default_nettype wire

// ==== rtl/strpi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module strpi_top #(
  // Identification codes, values arbitrary
  parameter logic [2:0] ID_VERSION = 3'h5,
  parameter logic [16:0] ID_TYPE = 17'h0_1234,
  parameter logic [10:0] ID_VENDOR = 11'h2ab
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Test link pins and controller state
  input wire logic tck,
  input wire logic tdi,
  input wire logic tap_reset,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  output logic tdo,
  output logic tdo_oe,
  // Memory pin ring
  input wire logic [107:0] ring_in,
  output logic [107:0] ring_out,
  output logic ring_drive,
  output logic q_bus_oe,
  // PLL control
  input wire logic pll_disable_n,
  output logic pll_enabled,
  output logic pll_locked
);

  // Whole block state
  typedef struct packed {
    logic tck_prev;
    logic [2:0] ir_sh;
    strpi_pkg::strpi_instr_e ir;
    logic byp;
    logic [31:0] id_sh;
    logic [108:0] bsr_sh;
    logic [108:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    logic q_bus_oe;
    logic ring_drive;
    logic [107:0] ring_out;
    logic [11:0] lock_cnt;
    logic pll_en;
    logic pll_locked;
  } strpi_top_s;

  strpi_top_s q;
  strpi_top_s d;
  logic [9:0] ctl; // Filtered control pins
  logic [107:0] ring_s; // Filtered ring inputs
  logic rise; // Test clock rising edge
  logic fall; // Test clock falling edge
  logic [31:0] id_word; // Fixed identification word

  // Boundary chain on the serial path
  function automatic logic sel_bsr(input strpi_pkg::strpi_instr_e ins);
    sel_bsr = (ins == strpi_pkg::INS_EXTEST) || (ins == strpi_pkg::INS_SAMPLE_Z) ||
      (ins == strpi_pkg::INS_SAMPLE);
  endfunction

  // Reserved codes fall back to bypass
  function automatic logic sel_byp(input strpi_pkg::strpi_instr_e ins);
    sel_byp = !sel_bsr(ins) && (ins != strpi_pkg::INS_IDCODE);
  endfunction

  // Control pins through three stages
  strpi_sync #(.W(strpi_pkg::CTL_W)) u_ctl_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in({pll_disable_n, update_ir, shift_ir, capture_ir, update_dr, shift_dr,
      capture_dr, tap_reset, tdi, tck}),
    .level(ctl)
  );

  // Ring inputs through three stages
  strpi_sync #(.W(strpi_pkg::RING_W)) u_ring_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(ring_in),
    .level(ring_s)
  );

  // Identification word fields
  assign id_word = {ID_VERSION, ID_TYPE, ID_VENDOR, 1'b1};

  // Next state
  always_comb
  begin
    d = q;
    rise = ctl[strpi_pkg::C_TCK] & ~q.tck_prev;
    fall = ~ctl[strpi_pkg::C_TCK] & q.tck_prev;
    d.tck_prev = ctl[strpi_pkg::C_TCK];
    // Capture and shift on the rising test clock
    if (rise)
    begin
      if (ctl[strpi_pkg::C_CIR])
      begin
        d.ir_sh = strpi_pkg::IR_CAPTURE;
      end
      else if (ctl[strpi_pkg::C_SIR])
      begin
        d.ir_sh = {ctl[strpi_pkg::C_TDI], q.ir_sh[2:1]};
      end
      if (ctl[strpi_pkg::C_CDR])
      begin
        if (q.ir == strpi_pkg::INS_IDCODE)
        begin
          d.id_sh = id_word;
        end
        else if (sel_bsr(q.ir))
        begin
          d.bsr_sh = {q.bsr_upd[strpi_pkg::OE_CELL], ring_s};
        end
        else
        begin
          d.byp = 1'b0;
        end
      end
      else if (ctl[strpi_pkg::C_SDR])
      begin
        if (q.ir == strpi_pkg::INS_IDCODE)
        begin
          d.id_sh = {ctl[strpi_pkg::C_TDI], q.id_sh[31:1]};
        end
        else if (sel_bsr(q.ir))
        begin
          d.bsr_sh = {ctl[strpi_pkg::C_TDI], q.bsr_sh[108:1]};
        end
        else
        begin
          d.byp = ctl[strpi_pkg::C_TDI];
        end
      end
    end
    // Update and drive out on the falling test clock
    if (fall)
    begin
      if (ctl[strpi_pkg::C_UIR])
      begin
        d.ir = strpi_pkg::strpi_instr_e'(q.ir_sh);
      end
      if (ctl[strpi_pkg::C_UDR] && sel_bsr(q.ir))
      begin
        d.bsr_upd = q.bsr_sh;
      end
      d.tdo_oe = ctl[strpi_pkg::C_SIR] | ctl[strpi_pkg::C_SDR];
      if (ctl[strpi_pkg::C_SIR])
      begin
        d.tdo = q.ir_sh[0];
      end
      else if (q.ir == strpi_pkg::INS_IDCODE)
      begin
        d.tdo = q.id_sh[0];
      end
      else if (sel_bsr(q.ir))
      begin
        d.tdo = q.bsr_sh[0];
      end
      else
      begin
        d.tdo = q.byp;
      end
    end
    // Controller reset state
    if (ctl[strpi_pkg::C_TLR])
    begin
      d.ir = strpi_pkg::IR_RESET;
      d.bsr_upd[strpi_pkg::OE_CELL] = strpi_pkg::OE_CELL_RESET;
    end
    // Read bus enable and ring drive
    if (q.ir == strpi_pkg::INS_EXTEST)
    begin
      d.q_bus_oe = q.bsr_upd[strpi_pkg::OE_CELL];
    end
    else
    begin
      d.q_bus_oe = (q.ir != strpi_pkg::INS_SAMPLE_Z);
    end
    d.ring_drive = (q.ir == strpi_pkg::INS_EXTEST);
    d.ring_out = q.bsr_upd[107:0];
    // PLL lock timer, counts only with the disable pin high
    d.pll_en = ctl[strpi_pkg::C_PLLN];
    if (!ctl[strpi_pkg::C_PLLN])
    begin
      d.lock_cnt = '0;
      d.pll_locked = 1'b0;
    end
    else if (q.lock_cnt != strpi_pkg::LOCK_W'(strpi_pkg::LOCK_CYC))
    begin
      d.lock_cnt = q.lock_cnt + 12'h001;
    end
    else
    begin
      d.pll_locked = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.ir <= strpi_pkg::IR_RESET;
      q.bsr_upd[strpi_pkg::OE_CELL] <= strpi_pkg::OE_CELL_RESET;
      q.q_bus_oe <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign tdo = q.tdo;
  assign tdo_oe = q.tdo_oe;
  assign ring_out = q.ring_out;
  assign ring_drive = q.ring_drive;
  assign q_bus_oe = q.q_bus_oe;
  assign pll_enabled = q.pll_en;
  assign pll_locked = q.pll_locked;

  // Capture step of the identification word
  sequence s_id_cap;
    ce && rise && ctl[strpi_pkg::C_CDR] && (q.ir == strpi_pkg::INS_IDCODE);
  endsequence

  property p_id_fields;
    @(posedge clk) disable iff (sys_rst)
    s_id_cap |=> (q.id_sh[31:29] == ID_VERSION) && (q.id_sh[28:12] == ID_TYPE) &&
      (q.id_sh[11:1] == ID_VENDOR);
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("ID fields wrong");

  property p_id_present;
    @(posedge clk) disable iff (sys_rst)
    s_id_cap |=> q.id_sh[0];
  endproperty
  a_id_present: assert property (p_id_present) else $error("ID bit 0 not one");
  property p_id_shift;
    @(posedge clk) disable iff (sys_rst)
    ce && rise && !ctl[strpi_pkg::C_CDR] && ctl[strpi_pkg::C_SDR] &&
      (q.ir == strpi_pkg::INS_IDCODE)
    |=> q.id_sh == {$past(ctl[strpi_pkg::C_TDI]), $past(q.id_sh[31:1])};
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("ID shift wrong");

  property p_bsr_cap;
    @(posedge clk) disable iff (sys_rst)
    ce && rise && ctl[strpi_pkg::C_CDR] && sel_bsr(q.ir) |=> q.bsr_sh[107:0] == $past(ring_s);
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("Ring not captured");
  property p_sample_z;
    @(posedge clk) disable iff (sys_rst)
    ce && (q.ir == strpi_pkg::INS_SAMPLE_Z) |=> !q_bus_oe;
  endproperty
  a_sample_z: assert property (p_sample_z) else $error("Bus not floated");

  property p_extest_oe;
    @(posedge clk) disable iff (sys_rst)
    ce && (q.ir == strpi_pkg::INS_EXTEST) |=> q_bus_oe == $past(q.bsr_upd[108]);
  endproperty
  a_extest_oe: assert property (p_extest_oe) else $error("Cell 108 ignored");
  property p_oe_preset;
    @(posedge clk) disable iff (sys_rst)
    ce && ctl[strpi_pkg::C_TLR] |=> q.bsr_upd[108] && (q.ir == strpi_pkg::INS_IDCODE);
  endproperty
  a_oe_preset: assert property (p_oe_preset) else $error("Reset preset missing");

  property p_bypass_out;
    @(posedge clk) disable iff (sys_rst)
    ce && fall && !ctl[strpi_pkg::C_SIR] && sel_byp(q.ir) |=> tdo == $past(q.byp);
  endproperty
  a_bypass_out: assert property (p_bypass_out) else $error("Bypass path wrong");
  property p_lock_time;
    @(posedge clk) disable iff (sys_rst)
    $rose(pll_locked) |-> $past(q.lock_cnt) == strpi_pkg::LOCK_W'(strpi_pkg::LOCK_CYC);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("Lock too early");

  property p_lock_drop;
    @(posedge clk) disable iff (sys_rst)
    ce && !ctl[strpi_pkg::C_PLLN] |=> !pll_locked && (q.lock_cnt == 12'h000);
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("Lock kept when disabled");

endmodule
`default_nettype wire

// ==== verif/strpi_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module strpi_ctl_model (
  // Clock
  input wire logic clk,
  // Link pins and controller state: tlr cdr sdr udr cir sir uir
  output logic tck,
  output logic tdi,
  output logic [6:0] st,
  // PLL pin
  output logic pll_disable_n,
  // Sample strobe for the monitor
  output logic smp
);
  // Power applied with the PLL pin at a defined low
  initial
  begin
    tck = 1'b0;
    tdi = 1'b0;
    st = 7'h00;
    pll_disable_n = 1'b0;
    smp = 1'b0;
  end

  // Enable the PLL and keep the pin high
  task automatic pll_on();
    @(negedge clk);
    pll_disable_n = 1'b1;
  endtask

  // One state: fall, rise, sample; 400 ns per state
  task automatic step(input logic [6:0] s, input logic d);
    @(negedge clk);
    st = s;
    tdi = d;
    smp = 1'b0;
    @(negedge clk);
    tck = 1'b0;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (2) @(negedge clk);
    smp = 1'b1;
  endtask

  // Capture, shift n bits LSB first, exit, update
  task automatic scan(input bit ir, input logic [108:0] d, input int n);
    logic l;
    l = d[n-1];
    step(ir ? 7'h10 : 7'h02, ~d[0]);
    for (int k = 0; k < n; k++)
      step(ir ? 7'h20 : 7'h04, d[k]);
    // Released data line shows the inverse
    step(7'h00, ~l);
    step(ir ? 7'h40 : 7'h08, l);
  endtask
endmodule
`default_nettype wire

// ==== verif/test_strpi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_strpi_top;
  // Clock, reset, pins
  logic clk;
  logic sys_rst;
  logic tck, tdi, smp, pll_disable_n, tdo, tdo_oe;
  logic ring_drive, q_bus_oe, pll_enabled, pll_locked;
  logic [6:0] st;
  logic [107:0] ring_in;
  logic [107:0] ring_out;
  // Expected bits and bookkeeping
  logic exp_q[$];
  int mismatches;
  int cmp_count;
  int n;
  logic c108;
  logic [127:0] rnd;
  logic [108:0] pat;
  logic [108:0] e;
  // Codes: sample, extest, sample_z, bypass, idcode, extest
  logic [2:0] codes[6] = '{3'h4, 3'h0, 3'h2, 3'h7, 3'h1, 3'h0};
  // Identification values, arbitrary
  localparam logic [2:0] VER = 3'h3;
  localparam logic [16:0] TYP = 17'h1_5a5a;
  localparam logic [10:0] VEN = 11'h135;
  localparam logic [31:0] IDW = {VER, TYP, VEN, 1'b1};

  strpi_top #(.ID_VERSION(VER), .ID_TYPE(TYP), .ID_VENDOR(VEN)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .tck(tck), .tdi(tdi),
    .tap_reset(st[0]), .capture_dr(st[1]), .shift_dr(st[2]), .update_dr(st[3]),
    .capture_ir(st[4]), .shift_ir(st[5]), .update_ir(st[6]), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
    .ring_drive(ring_drive), .q_bus_oe(q_bus_oe), .pll_disable_n(pll_disable_n),
    .pll_enabled(pll_enabled), .pll_locked(pll_locked)
  );

  strpi_ctl_model ctl (
    .clk(clk), .tck(tck), .tdi(tdi), .st(st), .pll_disable_n(pll_disable_n), .smp(smp)
  );

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string nm, input logic [108:0] seen, input logic [108:0] ex);
    cmp_count++;
    if (seen !== ex)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // Closing report
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Serial output monitor, one note per shift state
  always @(posedge smp)
    if (st[2] | st[5])
    begin
      check("tdo_oe", tdo_oe, 1'b1);
      if (exp_q.size() > 0)
        check("tdo", tdo, exp_q.pop_front());
    end

  // Data scan with expected bits noted first
  task automatic dr(input logic [108:0] ex, input logic [108:0] d, input int w);
    for (int k = 0; k < w; k++)
      exp_q.push_back(ex[k]);
    ctl.scan(1'b0, d, w);
  endtask

  // Instruction scan; capture pattern comes out
  task automatic ir(input logic [2:0] c);
    for (int k = 0; k < 3; k++)
      exp_q.push_back(strpi_pkg::IR_CAPTURE[k]);
    ctl.scan(1'b1, {106'h0, c}, 3);
  endtask

  // Read bus enable and ring drive per instruction
  task automatic outs(input logic [2:0] c);
    repeat (2) @(negedge clk);
    check("q_bus_oe", q_bus_oe, c == 3'h0 ? c108 : c != 3'h2);
    check("ring_drive", ring_drive, c == 3'h0);
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    ring_in = 108'h0;
    c108 = 1'b1;
    void'($urandom(19));
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    outs(3'h1);
    // PLL lock after 100 us of stable pin
    ctl.pll_on();
    n = 0;
    while (pll_locked !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (pll_locked !== 1'b1)
    begin
      mismatches++;
      give_verdict();
    end
    check("pll_enabled", pll_enabled, 1'b1);
    check("lock_early", n >= strpi_pkg::LOCK_CYC, 1'b1);
    check("lock_late", n <= strpi_pkg::LOCK_CYC + 8, 1'b1);
    // Identification word selected out of reset
    dr(IDW, 109'h0, 32);
    outs(3'h1);
    // Every defined instruction
    foreach (codes[i])
    begin
      ir(codes[i]);
      outs(codes[i]);
      rnd = {$urandom, $urandom, $urandom, $urandom};
      ring_in = rnd[107:0];
      rnd = {$urandom, $urandom, $urandom, $urandom};
      pat = {~i[0], rnd[107:0]};
      if (codes[i] == 3'h7)
        dr({101'h0, pat[6:0], 1'b0}, pat, 8);
      else if (codes[i] == 3'h1)
        dr(IDW, pat, 32);
      else
      begin
        e = {c108, ring_in};
        dr(e, pat, 109);
        c108 = pat[108];
        check("ring_out", ring_out, pat[107:0]);
      end
      outs(codes[i]);
    end
    // Link reset restores the instruction and presets the enable cell
    ctl.step(7'h01, 1'b0);
    ctl.step(7'h00, 1'b0);
    c108 = 1'b1;
    outs(3'h1);
    ir(3'h0);
    outs(3'h0);
    repeat (4) @(negedge clk);
    check("leftover", exp_q.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
